/* File: rtl/tpsu_shadow_bank.sv */
// shadow and working register bank with timed category updates
`timescale 1ns/1ps
module tpsu_shadow_bank (
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RST_B,
	// serial interface write side
	input  wire logic        I_WR_EN,
	input  wire logic [6:0]  I_WR_INDEX,
	input  wire logic [7:0]  I_WR_DATA,
	input  wire logic        I_MSG_DONE,
	input  wire logic        I_AUTO_INC_BUSY,
	// serial interface read side
	input  wire logic [6:0]  I_RD_INDEX,
	output logic      [7:0]  O_RD_DATA,
	// field timing points
	input  wire logic        I_ODD_FIRST_DARK_SAV,
	input  wire logic        I_ODD_FIRST_VIS_SAV,
	input  wire logic        I_ODD_EOF_SAV,
	input  wire logic        I_ODD_TO_EVEN,
	// working values to the sensor, and the pending flags
	output logic      [15:0] O_FINE_EXPOSURE,
	output logic      [15:0] O_COARSE_EXPOSURE,
	output logic      [7:0]  O_GAIN,
	output logic      [7:0]  O_CLOCK_DIVISOR,
	output logic      [15:0] O_H_START,
	output logic      [15:0] O_V_START,
	output logic      [7:0]  O_PRIMARY_SETUP,
	output logic      [3:0]  O_IGAIN,
	output logic      [5:0]  O_CGAIN,
	output logic      [6:0]  O_PENDING
);
	logic [7:0]                      shadow [0:tpsu_pkg::REG_COUNT-1];
	logic [7:0]                      work   [0:tpsu_pkg::REG_COUNT-1];
	logic [tpsu_pkg::P_COUNT-1:0]    pend;
	logic [tpsu_pkg::P_COUNT-1:0]    set_pend;
	logic [tpsu_pkg::P_COUNT-1:0]    copy;
	logic                            line_pend;
	logic                            wr;
	logic                            mode_flip;
	logic                            imm_gain;
	logic                            imm_clk;

	function automatic tpsu_pkg::tpsu_cat_e cat_of(input logic [6:0] idx);
		unique case (idx)
			tpsu_pkg::IDX_FINE0, tpsu_pkg::IDX_FINE1:
				cat_of = tpsu_pkg::CAT_FINE;
			tpsu_pkg::IDX_COARSE0, tpsu_pkg::IDX_COARSE1:
				cat_of = tpsu_pkg::CAT_COARSE;
			tpsu_pkg::IDX_GAIN:
				cat_of = tpsu_pkg::CAT_GAIN;
			tpsu_pkg::IDX_CLKDIV:
				cat_of = tpsu_pkg::CAT_CLK;
			tpsu_pkg::IDX_HSTART0, tpsu_pkg::IDX_HSTART1:
				cat_of = tpsu_pkg::CAT_PAN;
			tpsu_pkg::IDX_VSTART0, tpsu_pkg::IDX_VSTART1:
				cat_of = tpsu_pkg::CAT_TILT;
			tpsu_pkg::IDX_PRIMARY, tpsu_pkg::IDX_SECONDARY,
			tpsu_pkg::IDX_FRAME_GRAB, tpsu_pkg::IDX_ORIENT,
			tpsu_pkg::IDX_OUT_BUS, tpsu_pkg::IDX_OPTION,
			tpsu_pkg::IDX_BLACK_SET, tpsu_pkg::IDX_PIXOFS0,
			tpsu_pkg::IDX_PIXOFS1, tpsu_pkg::IDX_DARK_SET,
			tpsu_pkg::IDX_LINE0, tpsu_pkg::IDX_LINE1,
			tpsu_pkg::IDX_FIELD0, tpsu_pkg::IDX_FIELD1:
				cat_of = tpsu_pkg::CAT_VIDEO;
			default:
				cat_of = tpsu_pkg::CAT_NONE;
		endcase
	endfunction

	function automatic logic [3:0] div_nibble(input logic [1:0] mode);
		unique case (mode)
			tpsu_pkg::MODE_CIF:  div_nibble = tpsu_pkg::DIV_CIF;
			tpsu_pkg::MODE_QCIF: div_nibble = tpsu_pkg::DIV_QCIF;
			default:             div_nibble = tpsu_pkg::DIV_TV;
		endcase
	endfunction

	assign wr       = I_WR_EN && (I_WR_INDEX != tpsu_pkg::IDX_STATUS);
	assign imm_gain = shadow[tpsu_pkg::IDX_OPTION][tpsu_pkg::OPT_IMM_GAIN];
	assign imm_clk  = shadow[tpsu_pkg::IDX_OPTION][tpsu_pkg::OPT_IMM_CLK];
	assign mode_flip = I_WR_DATA[tpsu_pkg::SUBSAMPLE_BIT]
		!= shadow[tpsu_pkg::IDX_PRIMARY][tpsu_pkg::SUBSAMPLE_BIT];

	// which categories a write marks as pending
	always_comb begin
		tpsu_pkg::tpsu_cat_e c;
		logic                shuf_flip;
		logic                mirr_flip;
		c         = cat_of(I_WR_INDEX);
		shuf_flip = I_WR_DATA[tpsu_pkg::ORIENT_SHUF]
			!= shadow[tpsu_pkg::IDX_ORIENT][tpsu_pkg::ORIENT_SHUF];
		mirr_flip = I_WR_DATA[tpsu_pkg::ORIENT_MIRROR]
			!= shadow[tpsu_pkg::IDX_ORIENT][tpsu_pkg::ORIENT_MIRROR];
		set_pend  = '0;
		if (wr) begin
			unique case (c)
				tpsu_pkg::CAT_FINE:   set_pend[tpsu_pkg::P_FINE]   = 1'b1;
				tpsu_pkg::CAT_COARSE: set_pend[tpsu_pkg::P_COARSE] = 1'b1;
				tpsu_pkg::CAT_GAIN:   set_pend[tpsu_pkg::P_GAIN]   = 1'b1;
				tpsu_pkg::CAT_CLK:    set_pend[tpsu_pkg::P_CLK]    = 1'b1;
				tpsu_pkg::CAT_PAN:    set_pend[tpsu_pkg::P_PAN]    = 1'b1;
				tpsu_pkg::CAT_TILT:   set_pend[tpsu_pkg::P_TILT]   = 1'b1;
				tpsu_pkg::CAT_VIDEO:  set_pend[tpsu_pkg::P_VIDEO]  = 1'b1;
				tpsu_pkg::CAT_NONE:   set_pend = '0;
			endcase
			if (I_WR_INDEX == tpsu_pkg::IDX_PRIMARY && mode_flip) begin
				set_pend[tpsu_pkg::P_PAN]  = 1'b1;
				set_pend[tpsu_pkg::P_TILT] = 1'b1;
			end
			if (I_WR_INDEX == tpsu_pkg::IDX_SECONDARY
				&& I_WR_DATA[tpsu_pkg::HSHUFFLE_BIT]
				!= shadow[tpsu_pkg::IDX_SECONDARY][tpsu_pkg::HSHUFFLE_BIT])
				set_pend[tpsu_pkg::P_PAN] = 1'b1;
			if (I_WR_INDEX == tpsu_pkg::IDX_ORIENT) begin
				if (mirr_flip)
					set_pend[tpsu_pkg::P_PAN] = 1'b1;
				if (shuf_flip || mirr_flip)
					set_pend[tpsu_pkg::P_TILT] = 1'b1;
			end
		end
	end

	// update points; auto-increment blocks exposure, gain and divisor
	always_comb begin
		logic blk;
		blk = I_AUTO_INC_BUSY;
		copy = '0;
		copy[tpsu_pkg::P_COARSE] = pend[tpsu_pkg::P_COARSE] && !blk
			&& I_ODD_FIRST_DARK_SAV;
		copy[tpsu_pkg::P_TILT] = pend[tpsu_pkg::P_TILT]
			&& I_ODD_FIRST_VIS_SAV;
		// gain waits for the end-of-frame line, later in the same frame than coarse, or takes message end when imm_gain is set
		copy[tpsu_pkg::P_GAIN] = pend[tpsu_pkg::P_GAIN] && !blk
			&& (I_ODD_EOF_SAV || (I_MSG_DONE && imm_gain));
		copy[tpsu_pkg::P_PAN] = pend[tpsu_pkg::P_PAN] && I_ODD_EOF_SAV;
		copy[tpsu_pkg::P_FINE] = pend[tpsu_pkg::P_FINE] && !blk
			&& ((I_ODD_EOF_SAV && !line_pend)
			|| (I_ODD_TO_EVEN && line_pend));
		copy[tpsu_pkg::P_CLK] = pend[tpsu_pkg::P_CLK] && !blk
			&& (I_ODD_TO_EVEN || (I_MSG_DONE && imm_clk));
		copy[tpsu_pkg::P_VIDEO] = pend[tpsu_pkg::P_VIDEO] && I_ODD_TO_EVEN;
	end

	// shadow registers take every serial write but the status index; the divisor keeps its mode nibble
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			for (int i = 0; i < tpsu_pkg::REG_COUNT; i++)
				shadow[i] <= tpsu_pkg::REG_RESET;
		end else if (wr) begin
			if (I_WR_INDEX == tpsu_pkg::IDX_CLKDIV)
				shadow[I_WR_INDEX] <= {shadow[I_WR_INDEX][7:4],
					I_WR_DATA[3:0]};
			else
				shadow[I_WR_INDEX] <= I_WR_DATA;
			if (I_WR_INDEX == tpsu_pkg::IDX_PRIMARY)
				shadow[tpsu_pkg::IDX_CLKDIV][7:4] <= div_nibble(
					I_WR_DATA[tpsu_pkg::MODE_MSB:tpsu_pkg::MODE_LSB]);
		end
	end

	// working registers load by category; the divisor also rides the
	// video copy so that a mode change brings its new nibble along
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			for (int i = 0; i < tpsu_pkg::REG_COUNT; i++)
				work[i] <= tpsu_pkg::REG_RESET;
		end else begin
			for (int i = 0; i < tpsu_pkg::REG_COUNT; i++) begin
				tpsu_pkg::tpsu_cat_e c;
				c = cat_of(7'(i));
				if (c != tpsu_pkg::CAT_NONE && copy[int'(c)])
					work[i] <= shadow[i];
				else if (c == tpsu_pkg::CAT_CLK
					&& copy[tpsu_pkg::P_VIDEO] && !I_AUTO_INC_BUSY)
					work[i] <= shadow[i];
			end
		end
	end

	// a write landing with its copy leaves the flag set
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			pend <= '0;
		else
			pend <= (pend & ~copy) | set_pend;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			line_pend <= 1'b0;
		else if (wr && (I_WR_INDEX == tpsu_pkg::IDX_LINE0
			|| I_WR_INDEX == tpsu_pkg::IDX_LINE1))
			line_pend <= 1'b1;
		else if (copy[tpsu_pkg::P_VIDEO])
			line_pend <= 1'b0;
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			O_RD_DATA <= 8'h00;
		else if (I_RD_INDEX == tpsu_pkg::IDX_STATUS)
			O_RD_DATA <= {1'b0, pend};
		else
			O_RD_DATA <= shadow[I_RD_INDEX];
	end

	// gain split; current-gain limit of 12 is left to the master
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_IGAIN <= 4'h0;
			O_CGAIN <= 6'h00;
		end else begin
			logic [7:0] g;
			logic [1:0] m;
			g = work[tpsu_pkg::IDX_GAIN];
			m = work[tpsu_pkg::IDX_PRIMARY][tpsu_pkg::MODE_MSB:tpsu_pkg::MODE_LSB];
			if (work[tpsu_pkg::IDX_OPTION][tpsu_pkg::OPT_IGAIN_INV])
				O_IGAIN <= ~g[3:0];
			else
				O_IGAIN <= ~{g[0], g[1], g[2], g[3]};
			if (m == tpsu_pkg::MODE_CIF || m == tpsu_pkg::MODE_QCIF)
				O_CGAIN <= {g[7:4], tpsu_pkg::CGAIN_PAD};
			else
				O_CGAIN <= {1'b0, g[7:5], tpsu_pkg::CGAIN_PAD};
		end
	end

	assign O_PENDING         = pend;
	assign O_FINE_EXPOSURE   = {work[tpsu_pkg::IDX_FINE0],
		work[tpsu_pkg::IDX_FINE1]};
	assign O_COARSE_EXPOSURE = {work[tpsu_pkg::IDX_COARSE0],
		work[tpsu_pkg::IDX_COARSE1]};
	assign O_GAIN            = work[tpsu_pkg::IDX_GAIN];
	assign O_CLOCK_DIVISOR   = work[tpsu_pkg::IDX_CLKDIV];
	assign O_H_START         = {work[tpsu_pkg::IDX_HSTART0],
		work[tpsu_pkg::IDX_HSTART1]};
	assign O_V_START         = {work[tpsu_pkg::IDX_VSTART0],
		work[tpsu_pkg::IDX_VSTART1]};
	assign O_PRIMARY_SETUP   = work[tpsu_pkg::IDX_PRIMARY];
endmodule // tpsu_shadow_bank

/* File: rtl/tpsu_pkg.sv */
// constants for the timed parameter shadow/working register bank
package tpsu_pkg;
	// register indices on the serial interface
	localparam logic [6:0] IDX_STATUS     = 7'h02;
	localparam logic [6:0] IDX_PRIMARY    = 7'h10;
	localparam logic [6:0] IDX_SECONDARY  = 7'h11;
	localparam logic [6:0] IDX_FRAME_GRAB = 7'h14;
	localparam logic [6:0] IDX_ORIENT     = 7'h16;
	localparam logic [6:0] IDX_OUT_BUS    = 7'h17;
	localparam logic [6:0] IDX_OPTION     = 7'h18;
	localparam logic [6:0] IDX_FINE0      = 7'h20;
	localparam logic [6:0] IDX_FINE1      = 7'h21;
	localparam logic [6:0] IDX_COARSE0    = 7'h22;
	localparam logic [6:0] IDX_COARSE1    = 7'h23;
	localparam logic [6:0] IDX_GAIN       = 7'h24;
	localparam logic [6:0] IDX_CLKDIV     = 7'h25;
	localparam logic [6:0] IDX_BLACK_SET  = 7'h2b;
	localparam logic [6:0] IDX_PIXOFS0    = 7'h2c;
	localparam logic [6:0] IDX_PIXOFS1    = 7'h2d;
	localparam logic [6:0] IDX_DARK_SET   = 7'h2e;
	localparam logic [6:0] IDX_LINE0      = 7'h52;
	localparam logic [6:0] IDX_LINE1      = 7'h53;
	localparam logic [6:0] IDX_HSTART0    = 7'h57;
	localparam logic [6:0] IDX_HSTART1    = 7'h58;
	localparam logic [6:0] IDX_VSTART0    = 7'h59;
	localparam logic [6:0] IDX_VSTART1    = 7'h5a;
	localparam logic [6:0] IDX_FIELD0     = 7'h61;
	localparam logic [6:0] IDX_FIELD1     = 7'h62;
	localparam int         REG_COUNT      = 128;
	localparam logic [7:0] REG_RESET      = 8'h00;

	// field positions
	localparam int MODE_LSB      = 4;
	localparam int MODE_MSB      = 5;
	localparam int SUBSAMPLE_BIT = 6;
	localparam int HSHUFFLE_BIT  = 0;
	localparam int ORIENT_SHUF   = 0;
	localparam int ORIENT_MIRROR = 1;
	localparam int OPT_IGAIN_INV = 1;
	localparam int OPT_IMM_GAIN  = 2;
	localparam int OPT_IMM_CLK   = 3;

	// video modes in primary_setup
	localparam logic [1:0] MODE_PAL  = 2'h0;
	localparam logic [1:0] MODE_NTSC = 2'h1;
	localparam logic [1:0] MODE_CIF  = 2'h2;
	localparam logic [1:0] MODE_QCIF = 2'h3;

	// clock divisor upper nibble per mode
	localparam logic [3:0] DIV_CIF  = 4'h1;
	localparam logic [3:0] DIV_QCIF = 4'h3;
	localparam logic [3:0] DIV_TV   = 4'h0;

	localparam logic [1:0] CGAIN_PAD = 2'h3;

	// pending flag positions in timed_status_flags
	localparam int P_FINE   = 0;
	localparam int P_COARSE = 1;
	localparam int P_CLK    = 2;
	localparam int P_GAIN   = 3;
	localparam int P_PAN    = 4;
	localparam int P_TILT   = 5;
	localparam int P_VIDEO  = 6;
	localparam int P_COUNT  = 7;

	typedef enum logic [2:0] {
		CAT_FINE, CAT_COARSE, CAT_CLK, CAT_GAIN,
		CAT_PAN, CAT_TILT, CAT_VIDEO, CAT_NONE
	} tpsu_cat_e;
endpackage

/* File: tb/tpsu_checker.sv */
// port assertions for the shadow bank, bound to every instance
`timescale 1ns/1ps
module tpsu_checker (
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RST_B,
	// serial and timing inputs
	input  wire logic        I_WR_EN,
	input  wire logic [6:0]  I_WR_INDEX,
	input  wire logic        I_MSG_DONE,
	input  wire logic        I_AUTO_INC_BUSY,
	input  wire logic [6:0]  I_RD_INDEX,
	input  wire logic        I_ODD_FIRST_DARK_SAV,
	input  wire logic        I_ODD_EOF_SAV,
	input  wire logic        I_ODD_TO_EVEN,
	// design outputs
	input  wire logic [7:0]  O_RD_DATA,
	input  wire logic [15:0] O_COARSE_EXPOSURE,
	input  wire logic [7:0]  O_GAIN,
	input  wire logic [7:0]  O_CLOCK_DIVISOR,
	input  wire logic [7:0]  O_PRIMARY_SETUP,
	input  wire logic [5:0]  O_CGAIN,
	input  wire logic [6:0]  O_PENDING
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	function automatic logic [3:0] div_of(input logic [1:0] m);
		return (m == 2'h2) ? 4'h1 : (m == 2'h3) ? 4'h3 : 4'h0;
	endfunction
	status_read_a: assert property (I_RD_INDEX == 7'h02 |=>
		O_RD_DATA == {1'b0, $past(O_PENDING)}) else $error("status read");
	gain_pend_a: assert property (I_WR_EN && I_WR_INDEX == 7'h24 |=>
		O_PENDING[3]) else $error("gain pending");
	div_pend_a: assert property (I_WR_EN && I_WR_INDEX == 7'h25 |=>
		O_PENDING[2]) else $error("divisor pending");
	fine_pend_a: assert property (I_WR_EN && I_WR_INDEX == 7'h20 |=>
		O_PENDING[0]) else $error("fine pending");
	gain_timed_a: assert property ($changed(O_GAIN) |->
		$past(I_ODD_EOF_SAV || I_MSG_DONE)) else $error("gain moved");
	coarse_timed_a: assert property ($changed(O_COARSE_EXPOSURE) |->
		$past(I_ODD_FIRST_DARK_SAV)) else $error("coarse moved");
	div_timed_a: assert property ($changed(O_CLOCK_DIVISOR) |->
		$past(I_ODD_TO_EVEN || I_MSG_DONE)) else $error("divisor moved");
	busy_hold_a: assert property ($past(I_AUTO_INC_BUSY) |->
		$stable(O_GAIN) && $stable(O_COARSE_EXPOSURE) &&
		$stable(O_CLOCK_DIVISOR)) else $error("update while busy");
	div_mode_a: assert property ($past(I_ODD_TO_EVEN && !I_AUTO_INC_BUSY) |->
		O_CLOCK_DIVISOR[7:4] == div_of(O_PRIMARY_SETUP[5:4]))
		else $error("divisor mode nibble");
	// cgain lags the working gain by one cycle, so wait until it settles
	cgain_map_a: assert property ($changed(O_GAIN) ##1
		($stable(O_GAIN) && $stable(O_PRIMARY_SETUP)) |=> O_CGAIN ==
		{$past(O_PRIMARY_SETUP[5]) ? $past(O_GAIN[7:4]) :
		$past(O_GAIN[7:4]) >> 1, 2'h3}) else $error("cgain map");
	cover property (I_ODD_EOF_SAV && I_AUTO_INC_BUSY);
	cover property (I_MSG_DONE ##1 $changed(O_GAIN));
	cover property (I_ODD_TO_EVEN ##1 $changed(O_CLOCK_DIVISOR));
endmodule // tpsu_checker

bind tpsu_shadow_bank tpsu_checker tpsu_checker_i (.I_MCLK, .I_RST_B,
	.I_WR_EN, .I_WR_INDEX, .I_MSG_DONE, .I_AUTO_INC_BUSY, .I_RD_INDEX,
	.I_ODD_FIRST_DARK_SAV, .I_ODD_EOF_SAV, .I_ODD_TO_EVEN, .O_RD_DATA,
	.O_COARSE_EXPOSURE, .O_GAIN, .O_CLOCK_DIVISOR, .O_PRIMARY_SETUP,
	.O_CGAIN, .O_PENDING);

/* File: tb/tpsu_master_model.sv */
// serial-bus master model that programs the shadow bank
`timescale 1ns/1ps
module tpsu_master_model (
	// clock
	input  wire logic       i_mclk,
	// write side towards the bank
	output logic            o_wr_en,
	output logic [6:0]      o_wr_index,
	output logic [7:0]      o_wr_data,
	output logic            o_msg_done,
	output logic            o_busy
);
	initial begin
		o_wr_en = 1'b0;
		o_wr_index = 7'h00;
		o_wr_data = 8'h00;
		o_msg_done = 1'b0;
		o_busy = 1'b0;
	end
	// data is inverted after each byte so a stale byte never looks valid
	task automatic send(input logic [6:0] idx, input logic [7:0] d);
		@(posedge i_mclk);
		o_wr_en <= 1'b1;
		o_wr_index <= idx;
		o_wr_data <= d;
		@(posedge i_mclk);
		o_wr_en <= 1'b0;
		o_wr_data <= ~d;
		#1;
	endtask
	task automatic start();
		@(posedge i_mclk);
		o_busy <= 1'b1;
	endtask
	// end of message also ends any auto-increment run
	task automatic stop();
		@(posedge i_mclk);
		o_msg_done <= 1'b1;
		o_busy <= 1'b0;
		@(posedge i_mclk);
		o_msg_done <= 1'b0;
		#1;
	endtask
endmodule // tpsu_master_model

/* File: tb/tpsu_shadow_bank_bench.sv */
// self-checking bench for the timed parameter shadow bank
`timescale 1ns/1ps
module tpsu_shadow_bank_bench;
	logic        clk, rst_b, wr_en, msg_done, busy;
	logic [6:0]  wr_index, rd_index, pend;
	logic [7:0]  wr_data, rd_data, gain, div, setup;
	logic [15:0] coarse, fine, hstart, vstart;
	logic [3:0]  igain;
	logic [5:0]  cgain;
	logic [3:0]  tim;
	int          failures, comparisons, cycles;
	tpsu_master_model tpsu_master_model_i (.i_mclk(clk), .o_wr_en(wr_en),
		.o_wr_index(wr_index), .o_wr_data(wr_data), .o_msg_done(msg_done),
		.o_busy(busy));
	tpsu_shadow_bank tpsu_shadow_bank_i (.I_MCLK(clk), .I_RST_B(rst_b),
		.I_WR_EN(wr_en), .I_WR_INDEX(wr_index), .I_WR_DATA(wr_data),
		.I_MSG_DONE(msg_done), .I_AUTO_INC_BUSY(busy), .I_RD_INDEX(rd_index),
		.O_RD_DATA(rd_data), .I_ODD_FIRST_DARK_SAV(tim[0]),
		.I_ODD_FIRST_VIS_SAV(tim[1]), .I_ODD_EOF_SAV(tim[2]),
		.I_ODD_TO_EVEN(tim[3]), .O_FINE_EXPOSURE(fine),
		.O_COARSE_EXPOSURE(coarse), .O_GAIN(gain), .O_CLOCK_DIVISOR(div),
		.O_H_START(hstart), .O_V_START(vstart), .O_PRIMARY_SETUP(setup),
		.O_IGAIN(igain), .O_CGAIN(cgain), .O_PENDING(pend));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic w(input logic [6:0] i, input logic [7:0] d);
		tpsu_master_model_i.send(i, d);
	endtask
	// one-cycle timing point: 0 dark, 1 visible, 2 end of frame, 3 to even
	task automatic pulse(input int k);
		@(posedge clk);
		tim <= 4'h1 << k;
		@(posedge clk);
		tim <= 4'h0;
		#1;
	endtask
	task automatic rd(input logic [6:0] idx);
		@(posedge clk);
		rd_index <= idx;
		@(posedge clk);
		#1;
	endtask
	task automatic settle();
		@(posedge clk);
		#1;
	endtask
	task automatic t_gain();
		w(7'h10, 8'h20);
		w(7'h24, 8'hf3);
		w(7'h25, 8'hff);
		chk("gain early", gain, 8'h00);
		rd(7'h02);
		chk("status", rd_data, 8'h4c);
		pulse(2);
		chk("gain", gain, 8'hf3);
		settle();
		chk("cgain 9 bit", cgain, 6'h1f);
		chk("igain mirrored", igain, 4'h3);
		pulse(3);
		chk("divisor", div, 8'h1f);
		settle();
		chk("cgain 10 bit", cgain, 6'h3f);
		$display("gain test done");
	endtask
	task automatic t_clk();
		logic [3:0] dv [4] = '{4'h0, 4'h0, 4'h1, 4'h3};
		for (int m = 0; m < 4; m++) begin
			w(7'h10, {2'h0, m[1:0], 4'h0});
			pulse(3);
			chk("mode divisor", div, {dv[m], 4'hf});
		end
		$display("divisor test done");
	endtask
	task automatic t_busy();
		tpsu_master_model_i.start();
		w(7'h22, 8'h12);
		w(7'h23, 8'h34);
		w(7'h24, 8'h80);
		pulse(0);
		chk("coarse held", coarse, 16'h0000);
		pulse(2);
		chk("gain held", gain, 8'hf3);
		tpsu_master_model_i.stop();
		pulse(0);
		chk("coarse", coarse, 16'h1234);
		chk("gain waits", gain, 8'hf3);
		pulse(2);
		chk("gain", gain, 8'h80);
		$display("busy test done");
	endtask
	task automatic t_imm();
		w(7'h18, 8'h0c);
		w(7'h24, 8'h55);
		w(7'h25, 8'h03);
		w(7'h22, 8'h99);
		chk("gain early", gain, 8'h80);
		tpsu_master_model_i.stop();
		chk("gain now", gain, 8'h55);
		chk("divisor now", div, 8'h33);
		chk("coarse held", coarse, 16'h1234);
		settle();
		chk("igain now", igain, 4'h5);
		$display("immediate test done");
	endtask
	task automatic t_flags();
		w(7'h02, 8'hff);
		w(7'h57, 8'h01);
		w(7'h59, 8'h01);
		w(7'h52, 8'h01);
		w(7'h20, 8'h05);
		rd(7'h02);
		chk("status", rd_data, 8'h73);
		pulse(0);
		chk("pending dark", pend, 7'h71);
		pulse(1);
		chk("pending visible", pend, 7'h51);
		chk("tilt start", vstart, 16'h0100);
		pulse(2);
		chk("pending frame end", pend, 7'h41);
		chk("pan start", hstart, 16'h0100);
		chk("fine held", fine, 16'h0000);
		pulse(3);
		chk("pending to even", pend, 7'h00);
		chk("fine", fine, 16'h0500);
		$display("flag test done");
	endtask
	initial begin
		rst_b = 1'b0;
		rd_index = 7'h00;
		tim = 4'h0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_gain();
		t_clk();
		t_busy();
		t_imm();
		t_flags();
		end_sim();
	end
endmodule // tpsu_shadow_bank_bench
